/* File: bench/ssld_props.sv */
// concurrent checks on the link between controller and driver
`timescale 1ns/1ps
module ssld_props
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic sclk,
   input  wire logic sdata,
   input  wire logic load,
   input  wire logic blank,
   input  wire logic sdout
);
   logic        sclkPrev_q;
   logic        loadPrev_q;
   logic [3:0]  riseCnt_q;
   logic [11:0] hist_q;

   always_ff @(posedge core_clk)
   begin
      sclkPrev_q <= rst ? 1'b0 : sclk;
      loadPrev_q <= rst ? 1'b0 : load;
   end

   // bits seen at the pin, oldest in the top bit
   always_ff @(posedge core_clk)
   begin
      if (rst)
         hist_q <= 12'h000;
      else if (sclk && !sclkPrev_q)
         hist_q <= {hist_q[10:0], sdata};
   end

   // rises since the last load pulse; saturates so a runaway shows
   always_ff @(posedge core_clk)
   begin
      if (rst || (loadPrev_q && !load))
         riseCnt_q <= 4'h0;
      else if (sclk && !sclkPrev_q && riseCnt_q != 4'hf)
         riseCnt_q <= riseCnt_q + 4'h1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_clkHigh;
      sclk[*8] ##1 sclk[*2] ##1 !sclk;
   endsequence
   sequence s_loadPulse;
      load[*8] ##1 load[*2] ##1 !load;
   endsequence
   sequence s_gap;
      !sclk[*8] ##1 !sclk[*2];
   endsequence

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_dataSetup;  $rose(sclk) |-> $stable(sdata); endproperty
   property p_dataHold;   $rose(sclk) |=> $stable(sdata)[*4]; endproperty
   property p_clkHigh;    $rose(sclk) |-> s_clkHigh; endproperty
   property p_outEdge;    $changed(sdout) |-> !sclk; endproperty
   property p_outData;    $fell(sclk) |-> ##6 sdout == hist_q[11];
   endproperty
   property p_wordLen;    $rose(load) |-> riseCnt_q == 4'hc; endproperty
   property p_loadClkLow; load |-> !sclk; endproperty
   property p_loadWidth;  $rose(load) |-> s_loadPulse; endproperty
   property p_loadGap;    $fell(load) |-> s_gap; endproperty
   property p_resetQuiet;
      disable iff (1'b0) rst |=> !sclk && !load && !sdout;
   endproperty

   a_dataSetup:  assert property (p_dataSetup)
      else $error("data moved at clock rise");
   a_dataHold:   assert property (p_dataHold)
      else $error("data moved after clock rise");
   a_clkHigh:    assert property (p_clkHigh)
      else $error("clock high width wrong");
   a_outEdge:    assert property (p_outEdge)
      else $error("serial out moved while clock high");
   a_outData:    assert property (p_outData)
      else $error("serial out not the bit twelve rises old");
   a_wordLen:    assert property (p_wordLen)
      else $error("load not after twelve rises");
   a_loadClkLow: assert property (p_loadClkLow)
      else $error("clock high during load");
   a_loadWidth:  assert property (p_loadWidth)
      else $error("load pulse width wrong");
   a_loadGap:    assert property (p_loadGap)
      else $error("clock rose in gap after load");
   a_resetQuiet: assert property (p_resetQuiet)
      else $error("link not quiet in reset");
endmodule : ssld_props

/* File: bench/test_serial_shift_latch_driver.sv */
// self-checking bench: controller and driver joined over the link
`timescale 1ns/1ps
module test_serial_shift_latch_driver;
   logic        core_clk;
   logic        rst;
   logic        clkEn;
   logic [11:0] wordData;
   logic        wordValid;
   logic        blankReq;
   logic        wordReady_q;
   logic        busy_q;
   logic        sdoutSeen_q;
   logic [11:0] latchWord_q;
   logic [11:0] driverOutputs_q;
   int          failCount;
   int          checked;
   int          cycles;
   int          chkCnt;
   int          refused;
   logic        loadPrev;
   logic        curBlank;
   logic [11:0] cur;
   logic [11:0] lastWord;
   logic [11:0] expQ[$];

   ssld_if bus();
   ssld_host u_ssld_host (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
      .wordData(wordData), .wordValid(wordValid),
      .wordReady_q(wordReady_q), .blankReq(blankReq), .busy_q(busy_q),
      .sdoutSeen_q(sdoutSeen_q), .link(bus.host));
   ssld_device u_ssld_device (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
      .link(bus.dev), .driverOutputs_q(driverOutputs_q),
      .latchWord_q(latchWord_q));
   ssld_props u_ssld_props (.core_clk(core_clk), .rst(rst), .sclk(bus.sclk),
      .sdata(bus.sdata), .load(bus.load), .blank(bus.blank),
      .sdout(bus.sdout));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task check(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         failCount++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task endSim;
      if (failCount == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : endSim

   // valid is held across pushes so it never drops and rises in one step
   task push(input logic [11:0] w);
      wordData  <= w;
      wordValid <= 1'b1;
      @(posedge core_clk);
      while (wordReady_q !== 1'b1)
      begin
         refused++;
         @(posedge core_clk);
      end
      expQ.push_back(w);
      lastWord = w;
   endtask : push

   task batch(input int n, input logic bl);
      blankReq <= bl;
      curBlank = bl;
      repeat (n) push(12'($urandom_range(0, 4095)));
      wordValid <= 1'b0;
      while (expQ.size() != 0)
         @(posedge core_clk);
      repeat (30) @(posedge core_clk);
      // the writer must report idle once the last gap has run out
      check({11'h000, busy_q}, 12'h000);
   endtask : batch

   // model: each load fall delivers the oldest word sent
   always @(posedge core_clk)
   begin
      if (chkCnt == 1)
      begin
         check(latchWord_q, cur);
         check(driverOutputs_q, curBlank ? 12'h000 : cur);
         check({11'h000, sdoutSeen_q}, {11'h000, cur[11]});
      end
      if (chkCnt != 0)
         chkCnt--;
      if (loadPrev === 1'b1 && bus.load === 1'b0)
      begin
         check({11'h000, busy_q}, 12'h001);
         if (expQ.size() == 0)
            check(12'hfff, 12'h000);
         else
            cur = expQ.pop_front();
         chkCnt = 6;
      end
      loadPrev = bus.load;
   end

   // hang guard: the whole run needs about 4100 cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         failCount++;
         $display("ERROR %0t run did not finish", $time);
         endSim();
      end
   end

   initial
   begin
      logic bl;
      rst       = 1'b1;
      clkEn     = 1'b1;
      wordData  = 12'h000;
      wordValid = 1'b0;
      blankReq  = 1'b0;
      loadPrev  = 1'b0;
      void'($urandom(38));
      repeat (20) @(posedge core_clk);
      check(latchWord_q, 12'h000);
      check(driverOutputs_q, 12'h000);
      check({11'h000, sdoutSeen_q}, 12'h000);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      // ten back to back words overrun the eight-deep buffer
      batch(10, 1'b0);
      check({11'h000, refused == 0}, 12'h000);
      batch(3, 1'b1);
      batch(1, 1'b0);
      // blank toggles alone; latch must keep the last word
      for (int i = 0; i < 4; i++)
      begin
         bl = ~i[0];
         blankReq <= bl;
         repeat (6) @(posedge core_clk);
         check(latchWord_q, lastWord);
         check(driverOutputs_q, bl ? 12'h000 : lastWord);
      end
      // with the enable low a blank request must not reach the outputs
      clkEn    <= 1'b0;
      blankReq <= 1'b1;
      repeat (8) @(posedge core_clk);
      check(driverOutputs_q, lastWord);
      clkEn <= 1'b1;
      repeat (6) @(posedge core_clk);
      check(driverOutputs_q, 12'h000);
      check(latchWord_q, lastWord);
      // reset in mid-run must clear what the last word left behind
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(latchWord_q, 12'h000);
      check(driverOutputs_q, 12'h000);
      check({11'h000, busy_q}, 12'h000);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      batch(1, 1'b0);
      endSim();
   end
endmodule : test_serial_shift_latch_driver

/* File: rtl/ssld_device.sv */
// driver end: 12-bit shift register, transparent latch and blanking
//
// Notes on behaviour
// - controller holds data stable at rising clock
// - serial out changes on falling clock
// - serial out delays data by register length
// - blank high forces outputs low, latch kept
// - blank low, outputs follow latch bits
// - shifting and latching ignore the blank input
// - controller sends 12 bits, highest first
// - load falling edge leaves word held in latch
// - load high makes the latch transparent
// - every rising clock shifts, load regardless
// - latch holds newest 12 bits from load fall
// - shared lines need one load per device
// - shift register followed by transparent latch
// - reset clears state, outputs and serial out
// - rising clock shifts toward serial out
`timescale 1ns/1ps
module ssld_device
#(
   parameter int WIDTH = ssld_pkg::WORD_BITS
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   ssld_if.dev                   link,
   output logic [WIDTH-1:0]      driverOutputs_q,
   output logic [WIDTH-1:0]      latchWord_q
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   generate
      if (WIDTH < 2)
      begin : g_badWidth
         $error("ssld_device: WIDTH must be at least 2");
      end
   endgenerate

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // the pins belong to the controller's timing, so every one passes
   // two flops; all four share the same delay, which keeps their
   // relative order intact as long as the controller spaces its
   // edges by more than a core cycle
   logic [3:0] pinMeta_q;
   logic [3:0] pinSync_q;
   logic       sclkPrev_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pinMeta_q <= 4'h0;
         pinSync_q <= 4'h0;
      end
      else if (clkEn)
      begin
         pinMeta_q <= {link.blank, link.load, link.sdata, link.sclk};
         pinSync_q <= pinMeta_q;
      end
   end

   logic sclkS;
   logic dataS;
   logic loadS;
   logic blankS;

   always_comb
   begin
      sclkS  = pinSync_q[0];
      dataS  = pinSync_q[1];
      loadS  = pinSync_q[2];
      blankS = pinSync_q[3];
   end

   // ----------------------------------------------------------------
   // serial clock edges
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sclkPrev_q <= 1'b0;
      end
      else if (clkEn)
      begin
         sclkPrev_q <= sclkS;
      end
   end

   logic sclkRise;
   logic sclkFall;

   always_comb
   begin
      sclkRise = sclkS & ~sclkPrev_q;
      sclkFall = ~sclkS & sclkPrev_q;
   end

   // ----------------------------------------------------------------
   // shift register
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] shift_q;
   logic [WIDTH-1:0] shift_d;

   // no qualifier from load or blank: traffic for other parts on the
   // shared lines shifts through here as well
   always_comb
   begin
      shift_d = shift_q;
      if (sclkRise)
      begin
         shift_d = {shift_q[WIDTH-2:0], dataS};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         shift_q <= '0;
      end
      else if (clkEn)
      begin
         shift_q <= shift_d;
      end
   end

   // ----------------------------------------------------------------
   // serial output
   // ----------------------------------------------------------------
   // the last stage moves out only on the falling edge, so a cascaded
   // part samples a settled bit on its next rising edge; a bit taken
   // in therefore reaches the output after WIDTH clocks, not more
   logic sdout_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sdout_q <= 1'b0;
      end
      else if (clkEn && sclkFall)
      begin
         sdout_q <= shift_q[WIDTH-1];
      end
   end

   assign link.sdout = sdout_q;

   // ----------------------------------------------------------------
   // output latch
   // ----------------------------------------------------------------
   // transparent while load is high, so a shift in the same cycle is
   // already visible; after load falls the newest word stays put
   logic [WIDTH-1:0] latch_d;

   always_comb
   begin
      latch_d = latchWord_q;
      if (loadS)
      begin
         latch_d = shift_d;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         latchWord_q <= '0;
      end
      else if (clkEn)
      begin
         // blank plays no part in the latch
         latchWord_q <= latch_d;
      end
   end

   // ----------------------------------------------------------------
   // blanking gate
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         driverOutputs_q <= '0;
      end
      else if (clkEn)
      begin
         if (blankS)
         begin
            driverOutputs_q <= '0;
         end
         else
         begin
            // bit n of the latch drives output n
            driverOutputs_q <= latch_d;
         end
      end
   end

endmodule : ssld_device

/* File: rtl/ssld_host.sv */
// controller end: word FIFO and serial writer for the driver
`timescale 1ns/1ps

// ------------------------------------------------------------------
// word FIFO
// ------------------------------------------------------------------
module ssld_fifo
#(
   parameter int WIDTH = ssld_pkg::WORD_BITS,
   parameter int DEPTH = ssld_pkg::FIFO_DEPTH
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady_q,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid_q,
   input  wire logic             outReady
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_badDepth
         $error("ssld_fifo: DEPTH must be a power of two, 2 or more");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    rdPtr_q;
   logic [PW:0]      count_q;
   logic [PW:0]      count_d;
   logic             push;
   logic             pop;

   always_comb
   begin
      push    = inValid & inReady_q;
      pop     = outValid_q & outReady;
      count_d = count_q;
      if (push && !pop)
      begin
         count_d = count_q + 1'b1;
      end
      else if (pop && !push)
      begin
         count_d = count_q - 1'b1;
      end
   end

   assign outData = mem[rdPtr_q];

   always_ff @(posedge core_clk)
   begin
      if (clkEn && push)
      begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wrPtr_q    <= '0;
         rdPtr_q    <= '0;
         count_q    <= '0;
         inReady_q  <= 1'b0;
         outValid_q <= 1'b0;
      end
      else if (clkEn)
      begin
         wrPtr_q    <= wrPtr_q + PW'(push);
         rdPtr_q    <= rdPtr_q + PW'(pop);
         count_q    <= count_d;
         inReady_q  <= (count_d != (PW+1)'(DEPTH));
         outValid_q <= (count_d != '0);
      end
   end
endmodule : ssld_fifo

// ------------------------------------------------------------------
// serial writer
// ------------------------------------------------------------------
module ssld_host
#(
   parameter int WIDTH = ssld_pkg::WORD_BITS,
   parameter int DEPTH = ssld_pkg::FIFO_DEPTH
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] wordData,
   input  wire logic             wordValid,
   output logic                  wordReady_q,
   input  wire logic             blankReq,
   output logic                  busy_q,
   output logic                  sdoutSeen_q,
   ssld_if.host                  link
);
   localparam int BW = (WIDTH > 1) ? $clog2(WIDTH) : 1;

   generate
      if (ssld_pkg::LINK_HALF_CYC > 255 || ssld_pkg::LOAD_HIGH_CYC > 255
          || ssld_pkg::LOAD_GAP_CYC > 255)
      begin : g_badTime
         $error("ssld_host: timing counts exceed the counter");
      end
   endgenerate

   typedef enum logic [2:0] {IDLE, BIT_LOW, BIT_HIGH, LOAD_HI, GAP}
      ssld_hstate_t;

   ssld_hstate_t     state_q;
   logic [WIDTH-1:0] word_q;
   logic [BW-1:0]    bitIdx_q;
   logic [7:0]       cnt_q;
   logic             sclk_q;
   logic             sdata_q;
   logic             load_q;
   logic             blank_q;
   logic             sdoutMeta_q;
   logic [WIDTH-1:0] fifoData;
   logic             fifoValid;
   logic             take;

   ssld_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo
   (
      .core_clk   (core_clk),
      .rst        (rst),
      .clkEn      (clkEn),
      .inData     (wordData),
      .inValid    (wordValid),
      .inReady_q  (wordReady_q),
      .outData    (fifoData),
      .outValid_q (fifoValid),
      .outReady   (take)
   );

   // a word leaves the FIFO only when the writer is idle, so a slow
   // link fills the FIFO and stalls the source
   assign take = (state_q == IDLE);

   // ----------------------------------------------------------------
   // link sequencer
   // ----------------------------------------------------------------
   // data changes only while the serial clock is low, a full half
   // period before each rising edge
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q  <= IDLE;
         word_q   <= '0;
         bitIdx_q <= '0;
         cnt_q    <= '0;
         sclk_q   <= 1'b0;
         sdata_q  <= 1'b0;
         load_q   <= 1'b0;
         busy_q   <= 1'b0;
      end
      else if (clkEn)
      begin
         if (cnt_q != '0)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
         case (state_q)
            IDLE:
            begin
               sclk_q <= 1'b0;
               if (fifoValid)
               begin
                  word_q   <= fifoData;
                  bitIdx_q <= BW'(WIDTH - 1);
                  sdata_q  <= fifoData[WIDTH-1];
                  cnt_q    <= 8'(ssld_pkg::LINK_HALF_CYC - 1);
                  busy_q   <= 1'b1;
                  state_q  <= BIT_LOW;
               end
               else
               begin
                  busy_q <= 1'b0;
               end
            end
            BIT_LOW:
            begin
               if (cnt_q == '0)
               begin
                  sclk_q  <= 1'b1;
                  cnt_q   <= 8'(ssld_pkg::LINK_HALF_CYC - 1);
                  state_q <= BIT_HIGH;
               end
            end
            BIT_HIGH:
            begin
               if (cnt_q == '0)
               begin
                  sclk_q <= 1'b0;
                  if (bitIdx_q == '0)
                  begin
                     load_q  <= 1'b1;
                     cnt_q   <= 8'(ssld_pkg::LOAD_HIGH_CYC - 1);
                     state_q <= LOAD_HI;
                  end
                  else
                  begin
                     bitIdx_q <= bitIdx_q - 1'b1;
                     sdata_q  <= word_q[bitIdx_q - 1'b1];
                     cnt_q    <= 8'(ssld_pkg::LINK_HALF_CYC - 1);
                     state_q  <= BIT_LOW;
                  end
               end
            end
            LOAD_HI:
            begin
               if (cnt_q == '0)
               begin
                  load_q  <= 1'b0;
                  cnt_q   <= 8'(ssld_pkg::LOAD_GAP_CYC - 1);
                  state_q <= GAP;
               end
            end
            GAP:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= IDLE;
               end
            end
            default:
            begin
               state_q <= IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // blank and cascade readback
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         blank_q     <= 1'b0;
         sdoutMeta_q <= 1'b0;
         sdoutSeen_q <= 1'b0;
      end
      else if (clkEn)
      begin
         blank_q     <= blankReq;
         sdoutMeta_q <= link.sdout;
         sdoutSeen_q <= sdoutMeta_q;
      end
   end

   assign link.sclk  = sclk_q;
   assign link.sdata = sdata_q;
   assign link.load  = load_q;
   assign link.blank = blank_q;

endmodule : ssld_host

/* File: rtl/ssld_if.sv */
// pins between the display controller and the shift/latch driver
`timescale 1ns/1ps
interface ssld_if;
   logic sclk;
   logic sdata;
   logic load;
   logic blank;
   logic sdout;

   modport host
   (
      output sclk,
      output sdata,
      output load,
      output blank,
      input  sdout
   );

   modport dev
   (
      input  sclk,
      input  sdata,
      input  load,
      input  blank,
      output sdout
   );
endinterface : ssld_if

/* File: rtl/ssld_pkg.sv */
// shared constants for the serial shift/latch driver and its controller
package ssld_pkg;

   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int             WORD_BITS  = 12;
   localparam logic [11:0]    WORD_RESET = 12'h000;
   localparam int             MSB_POS    = WORD_BITS - 1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CORE_CLK_NS   = 10;
   // least half period of the serial clock (high and low alike)
   localparam int LINK_HALF_NS  = 100;
   localparam int LINK_HALF_CYC =
      (LINK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   // least width of the load pulse
   localparam int LOAD_HIGH_NS  = 100;
   localparam int LOAD_HIGH_CYC =
      (LOAD_HIGH_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   // quiet gap after load falls, before the next word
   localparam int LOAD_GAP_NS   = 100;
   localparam int LOAD_GAP_CYC  =
      (LOAD_GAP_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

   // ----------------------------------------------------------------
   // buffering
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 8;

endpackage : ssld_pkg
